// File: shared/uabd_regs.vh
/*
  register offsets, field positions, reset values and timing counts
  for the autobaud detect block. assumes an 8-bit register port.
*/
`ifndef UABD_REGS_VH
`define UABD_REGS_VH
// ----------------------------------------
// offsets
// ----------------------------------------
`define UABD_ADDR_DIV_LOW 4'h0
`define UABD_ADDR_DIV_HIGH 4'h1
`define UABD_ADDR_BAUD_CTRL 4'h2
`define UABD_ADDR_MODE 4'h3
`define UABD_ADDR_RX_BUF 4'h4
`define UABD_ADDR_STATUS 4'h5
// ----------------------------------------
// baud control fields
// ----------------------------------------
`define UABD_BC_ABEN 0
`define UABD_BC_WAKE 1
`define UABD_BC_WIDE 3
`define UABD_BC_OVF 7
// ----------------------------------------
// mode fields
// ----------------------------------------
`define UABD_MD_HSPD 2
`define UABD_MD_SYNC 4
// ----------------------------------------
// status fields
// ----------------------------------------
`define UABD_ST_RXIF 0
`define UABD_ST_RXIDLE 1
`define UABD_ST_BRK 2
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define UABD_RST_BYTE 8'h00
`define UABD_DIV_512 10'h1ff
`define UABD_DIV_128 10'h07f
`define UABD_DIV_32 10'h01f
`define UABD_EDGES 3'h5
`endif

// File: logic/uabd_prescale.v
/*
  measurement prescaler: one-cycle tick every divide+1 oscillator clocks.
  assumes the divide value is steady while running.
*/
`timescale 1ns/1ps
`include "uabd_regs.vh"
module uabd_prescale (
  input wire mclk,
  input wire resetn,
  input wire run,
  input wire [9:0] divide,
  output wire tick
);
  reg [9:0] cnt_reg;
  assign tick = run && (cnt_reg == divide);
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 10'h000;
    end else if (!run || tick) begin
      cnt_reg <= 10'h000;
    end else begin
      cnt_reg <= cnt_reg + 10'h001;
    end
  end
endmodule

// File: logic/uabd_edge.v
/*
  rising and falling edge finder on the receive pin.
  assumes the pin is already synchronous to mclk.
*/
`timescale 1ns/1ps
module uabd_edge (
  input wire mclk,
  input wire resetn,
  input wire din,
  output wire rise,
  output wire fall
);
  reg last_reg;
  assign rise = din && !last_reg;
  assign fall = !din && last_reg;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      last_reg <= 1'b1;
    end else begin
      last_reg <= din;
    end
  end
endmodule

// File: logic/uabd_top.v
/*
  autobaud detection for an enhanced serial port: registers, control
  machine and 16-bit rate generator counter. assumes the receive pin
  is synchronous to mclk, and break detection is signalled by the
  receiver elsewhere on break_seen.
*/
`timescale 1ns/1ps
`include "uabd_regs.vh"
// Behaviour
// - detect only in async mode, except a measurement already running
// - start bit with enable starts measurement
// - enable clears counter, then awaits start
// - count from first rising edge onward
// - fifth rising edge leaves bit period
// - enable clears itself at fifth edge
// - rollover sets overflow flag bit seven
// - software may set or clear overflow
// - rollover keeps detection and enable active
// - counter clocked at one eighth rate
// - prescale 512, 128 or 32 per selection
// - both divisor bytes form one counter
// - receiver held idle during detection
// - fifth edge sets receive interrupt flag
// - with wake on, detect after break
// - lsb first, start, data, stop framing
// - normal generator at x16 or x64
module uabd_top (
  input wire mclk,
  input wire resetn,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire serial_receive_pin,
  input wire break_seen,
  input wire [7:0] rx_data,
  output reg receive_interrupt_flag,
  output reg rx_hold_idle,
  output reg brg_tick,
  output reg autobaud_active
);
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_MEAS = 2'h2;
  localparam ST_BREAK = 2'h3;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [1:0] state_reg;
  reg [15:0] div_reg;
  reg autobaud_enable_reg;
  reg wake_on_break_enable_reg;
  reg wide_divisor_select_reg;
  reg autobaud_overflow_flag_reg;
  reg high_speed_select_reg;
  reg sync_mode_reg;
  reg [2:0] edge_cnt_reg;
  reg [15:0] gen_cnt_reg;
  reg [5:0] phase_reg;
  reg [7:0] rx_buf_reg;
  wire rise;
  wire fall;
  wire pre_tick;
  reg [9:0] pre_div;
  wire measuring;
  wire detect_ok;
  wire fifth;
  wire rollover;
  wire wr_ctrl;
  assign measuring = (state_reg == ST_MEAS);
  assign detect_ok = !sync_mode_reg;
  assign fifth = measuring && rise && (edge_cnt_reg == `UABD_EDGES - 3'h1);
  assign rollover = measuring && pre_tick && (div_reg == 16'hffff);
  assign wr_ctrl = wr && (addr == `UABD_ADDR_BAUD_CTRL);
  // ----------------------------------------
  // measurement clock select
  // ----------------------------------------
  always @* begin
    case ({wide_divisor_select_reg, high_speed_select_reg})
      2'b00: pre_div = `UABD_DIV_512;
      2'b11: pre_div = `UABD_DIV_32;
      default: pre_div = `UABD_DIV_128;
    endcase
  end
  uabd_prescale u_pre (
    .mclk(mclk),
    .resetn(resetn),
    .run(measuring && edge_cnt_reg != 3'h0),
    .divide(pre_div),
    .tick(pre_tick)
  );
  uabd_edge u_edge (
    .mclk(mclk),
    .resetn(resetn),
    .din(serial_receive_pin),
    .rise(rise),
    .fall(fall)
  );
  // ----------------------------------------
  // control machine
  // ----------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      edge_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          edge_cnt_reg <= 3'h0;
          if (autobaud_enable_reg && detect_ok) begin
            state_reg <= wake_on_break_enable_reg ? ST_BREAK : ST_START;
          end
        end
        ST_BREAK: begin
          if (!autobaud_enable_reg || !detect_ok) begin
            state_reg <= ST_IDLE;
          end else if (break_seen) begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (!autobaud_enable_reg || !detect_ok) begin
            state_reg <= ST_IDLE;
          end else if (fall) begin
            state_reg <= ST_MEAS;
          end
        end
        ST_MEAS: begin
          if (!autobaud_enable_reg || fifth) begin
            state_reg <= ST_IDLE;
          end else if (rise) begin
            edge_cnt_reg <= edge_cnt_reg + 3'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // divisor pair and baud control
  // ----------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 16'h0000;
      autobaud_enable_reg <= 1'b0;
      wake_on_break_enable_reg <= 1'b0;
      wide_divisor_select_reg <= 1'b0;
      autobaud_overflow_flag_reg <= 1'b0;
      high_speed_select_reg <= 1'b0;
      sync_mode_reg <= 1'b0;
    end else begin
      if (wr && addr == `UABD_ADDR_MODE) begin
        high_speed_select_reg <= wdata[`UABD_MD_HSPD];
        sync_mode_reg <= wdata[`UABD_MD_SYNC];
      end
      if (wr_ctrl) begin
        wake_on_break_enable_reg <= wdata[`UABD_BC_WAKE];
        wide_divisor_select_reg <= wdata[`UABD_BC_WIDE];
      end
      // enable clears on fifth edge; rollover leaves it set
      if (fifth) begin
        autobaud_enable_reg <= 1'b0;
      end else if (wr_ctrl) begin
        autobaud_enable_reg <= wdata[`UABD_BC_ABEN];
      end
      // hardware set wins over software clear
      if (rollover) begin
        autobaud_overflow_flag_reg <= 1'b1;
      end else if (wr_ctrl) begin
        autobaud_overflow_flag_reg <= wdata[`UABD_BC_OVF];
      end
      if (state_reg == ST_IDLE && autobaud_enable_reg && detect_ok) begin
        div_reg <= 16'h0000;
      end else if (measuring && pre_tick) begin
        div_reg <= div_reg + 16'h0001;
      end else if (!measuring && wr && addr == `UABD_ADDR_DIV_LOW) begin
        div_reg[7:0] <= wdata;
      end else if (!measuring && wr && addr == `UABD_ADDR_DIV_HIGH) begin
        div_reg[15:8] <= wdata;
      end
    end
  end
  // ----------------------------------------
  // normal rate generator
  // ----------------------------------------
  // x16 or x64 clock; fast wide mode gives bit rate fosc/(4*(n+1))
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gen_cnt_reg <= 16'h0000;
      phase_reg <= 6'h00;
      brg_tick <= 1'b0;
    end else if (state_reg != ST_IDLE) begin
      gen_cnt_reg <= 16'h0000;
      phase_reg <= 6'h00;
      brg_tick <= 1'b0;
    end else begin
      brg_tick <= 1'b0;
      if (phase_reg != 6'h00) begin
        phase_reg <= phase_reg - 6'h01;
      end else if (gen_cnt_reg == 16'h0000) begin
        gen_cnt_reg <= wide_divisor_select_reg ? div_reg : {8'h00, div_reg[7:0]};
        brg_tick <= 1'b1;
        // phase stretches the oscillator into the per-tick prescale
        case ({wide_divisor_select_reg, high_speed_select_reg})
          2'b11: phase_reg <= 6'h00;
          2'b00: phase_reg <= 6'h03;
          default: phase_reg <= 6'h00;
        endcase
      end else begin
        gen_cnt_reg <= gen_cnt_reg - 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // receive flag, hold and read port
  // ----------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      receive_interrupt_flag <= 1'b0;
      rx_hold_idle <= 1'b0;
      autobaud_active <= 1'b0;
      rx_buf_reg <= `UABD_RST_BYTE;
      rdata <= `UABD_RST_BYTE;
    end else begin
      rx_hold_idle <= (state_reg == ST_START) || measuring;
      autobaud_active <= autobaud_enable_reg;
      if (fifth) begin
        receive_interrupt_flag <= 1'b1;
        rx_buf_reg <= rx_data;
      end else if (rd && addr == `UABD_ADDR_RX_BUF) begin
        receive_interrupt_flag <= 1'b0;
      end
      rdata <= `UABD_RST_BYTE;
      if (rd) begin
        case (addr)
          `UABD_ADDR_DIV_LOW: rdata <= div_reg[7:0];
          `UABD_ADDR_DIV_HIGH: rdata <= div_reg[15:8];
          `UABD_ADDR_BAUD_CTRL: rdata <= {autobaud_overflow_flag_reg, 3'h0,
            wide_divisor_select_reg, 1'b0, wake_on_break_enable_reg, autobaud_enable_reg};
          `UABD_ADDR_MODE: rdata <= {3'h0, sync_mode_reg, 1'b0, high_speed_select_reg, 2'h0};
          `UABD_ADDR_RX_BUF: rdata <= rx_buf_reg;
          `UABD_ADDR_STATUS: rdata <= {5'h00, state_reg == ST_BREAK, rx_hold_idle,
            receive_interrupt_flag};
          default: rdata <= `UABD_RST_BYTE;
        endcase
      end
    end
  end
endmodule

// File: tb/uabd_sender.sv
/*
  remote sender model: one 55h sync character per go pulse.
  assumes go is a one-cycle pulse given while not busy.
*/
`timescale 1ns/1ps
module uabd_sender (
  input wire mclk,
  input wire go,
  input wire [15:0] bit_cycles,
  output reg line,
  output reg busy
);
  // ----------------------------------------
  // frame shifter, idle high
  // ----------------------------------------
  wire [9:0] frame = {1'b1, 8'h55, 1'b0};
  reg [3:0] idx;
  reg [15:0] cnt;
  initial begin
    line = 1'b1;
    busy = 1'b0;
  end
  always @(posedge mclk) begin
    if (!busy && go) begin
      busy <= 1'b1;
      idx <= 4'h0;
      cnt <= 16'h0000;
      line <= frame[0];
    end else if (busy) begin
      if (cnt == bit_cycles - 16'h0001) begin
        cnt <= 16'h0000;
        idx <= idx + 4'h1;
        if (idx == 4'h9)
          busy <= 1'b0;
        else
          line <= frame[idx + 4'h1];
      end else
        cnt <= cnt + 16'h0001;
    end
  end
endmodule

// File: tb/uabd_checker.sv
/*
  port checker for the autobaud block.
  assumes one clock and resetn active low.
*/
`timescale 1ns/1ps
module uabd_checker (
  input wire mclk,
  input wire resetn,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire receive_interrupt_flag,
  input wire rx_hold_idle,
  input wire brg_tick,
  input wire autobaud_active
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_tick_quiet: assert property (
    rx_hold_idle && $past(rx_hold_idle) |-> !brg_tick) else $error("tick while measuring");
  a_flag_clear: assert property (
    rd && addr == 4'h4 |=> !receive_interrupt_flag) else $error("flag kept after read");
  a_flag_stays: assert property (
    receive_interrupt_flag && !(rd && addr == 4'h4) |=> receive_interrupt_flag)
    else $error("flag dropped");
  a_flag_done: assert property (
    $rose(receive_interrupt_flag) |-> ##[0:1] !autobaud_active) else $error("enable kept");
  a_flag_held: assert property (
    $rose(receive_interrupt_flag) |-> $past(rx_hold_idle)) else $error("receiver not held");
  a_flag_enabled: assert property (
    $rose(receive_interrupt_flag) |-> autobaud_active) else $error("flag without enable");
  a_active_write: assert property (
    $rose(autobaud_active) |-> $past(wr, 2) && $past(addr, 2) == 4'h2 && $past(wdata[0], 2))
    else $error("enable without write");
  a_hold_release: assert property (
    $fell(autobaud_active) |-> ##[0:1] !rx_hold_idle) else $error("hold kept");
endmodule

// File: tb/uabd_top_test.sv
/*
  self-checking bench for the autobaud block.
  assumes the sender model and the checker bound beside it.
*/
`timescale 1ns/1ps
module uabd_top_test;
  reg mclk, resetn, wr, rd, break_seen, go;
  reg [3:0] addr;
  reg [7:0] wdata, d;
  reg [15:0] bit_cycles;
  wire [7:0] rdata;
  wire line, busy, rxf, hold, tick, act;
  integer mismatches, num_checks, i, n;
  uabd_top dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .serial_receive_pin(line), .break_seen(break_seen), .rx_data(8'h3c),
    .receive_interrupt_flag(rxf), .rx_hold_idle(hold), .brg_tick(tick), .autobaud_active(act));
  uabd_sender far (.mclk(mclk), .go(go), .bit_cycles(bit_cycles), .line(line), .busy(busy));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [7:0] v);
    begin
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
    end
  endtask
  task rd_reg(input [3:0] a);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task send;
    begin
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      #1 n = 0;
      while (busy !== 1'b0 && n < 40000) begin
        @(posedge mclk);
        n = n + 1;
      end
      if (n >= 40000)
        mismatches = mismatches + 1;
      #1;
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #5000000;
    mismatches = mismatches + 1;
    conclude;
  end
  initial begin
    {resetn, wr, rd, break_seen, go, addr, wdata} = 0;
    bit_cycles = 16'd1024;
    mismatches = 0;
    num_checks = 0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rd_reg(4'h2); check(d, 8'h00);
    wr_reg(4'h2, 8'h80); rd_reg(4'h2); check(d, 8'h80);
    wr_reg(4'h2, 8'h00); rd_reg(4'h2); check(d, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      bit_cycles <= 16'd1024 >> (2 * (i[0] + i[1]));
      wr_reg(4'h3, {5'h00, i[0], 2'b00});
      wr_reg(4'h0, 8'hab);
      wr_reg(4'h2, {4'h0, i[1], 3'b001});
      @(posedge mclk);
      #1 rd_reg(4'h0); check(d, 8'h00);
      check(hold, 1'b1);
      send;
      rd_reg(4'h2); check(d, {4'h0, i[1], 3'b000});
      rd_reg(4'h1); check(d, 8'h00);
      rd_reg(4'h0); check(d >= 8'd15 && d <= 8'd16, 1'b1);
      rd_reg(4'h5); check(d, 8'h01);
      rd_reg(4'h4); check(d, 8'h3c);
      rd_reg(4'h5); check(d, 8'h00);
    end
    wr_reg(4'h3, 8'h14);
    wr_reg(4'h2, 8'h09);
    send; check(rxf, 1'b0);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h3, 8'h04);
    wr_reg(4'h2, 8'h0b);
    send; check(rxf, 1'b0);
    break_seen <= 1'b1;
    @(posedge mclk);
    break_seen <= 1'b0;
    #1 send; check(rxf, 1'b1);
    rd_reg(4'h0); check(d >= 8'd15 && d <= 8'd16, 1'b1);
    rd_reg(4'h4);
    wr_reg(4'h2, 8'h08);
    wr_reg(4'h0, 8'h03);
    n = 0;
    repeat (40) begin
      @(posedge mclk);
      #1 n = n + (tick === 1'b1);
    end
    check(n >= 5, 1'b1);
    conclude;
  end
endmodule
bind uabd_top uabd_checker chk (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .receive_interrupt_flag(receive_interrupt_flag),
  .rx_hold_idle(rx_hold_idle), .brg_tick(brg_tick), .autobaud_active(autobaud_active));
